// file: dual_serial_source_failover.sv
// The register offsets and register access over Wishbone were decided locally.
`default_nettype none

// How it works
// [RULE1] In secondary-as-primary mode the secondary port feeds the primary slot and the primary port the first backup slot.
// [RULE2] In secondary-as-backup mode the primary port feeds the primary slot and the secondary port the first backup slot.
// [RULE3] A failed primary callout moves straight to the first backup with no second attempt.
// [RULE4] A first backup is only judged failed by the result of its own callout.
// [RULE5] When the first backup fails and a second backup exists, the second backup is called.
// [RULE6] When no source is left, time runs free internally.
// [RULE7] In dual-port mode the internal phone modem is never a selectable source.
// [RULE8] In dual-port mode the second backup slot stays empty.
// [RULE9] Each source's last callout result is kept, and a good result makes its time valid.
// [RULE10] The dual-port mode has off and two mapping values and re-routes the slots as soon as it changes.
module dual_serial_source_failover (
    input wire logic clk,
    input wire logic nrst,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [failover_pkg::ADDR_WIDTH-1:0] wb_adr_i,
    input wire logic [failover_pkg::SEL_WIDTH-1:0] wb_sel_i,
    input wire logic [failover_pkg::DATA_WIDTH-1:0] wb_dat_i,
    output logic [failover_pkg::DATA_WIDTH-1:0] wb_dat_o,
    output logic wb_ack_o,
    output logic callReq,
    output failover_pkg::source_type callSource,
    input wire logic callDone,
    input wire logic callOk,
    output failover_pkg::source_type activeSource,
    output logic timeValid,
    output logic freeRun
);
    import failover_pkg::*;

    // Bus and configuration state
    logic ackReg, ackNext;
    logic [DATA_WIDTH-1:0] rdataReg, rdataNext;
    logic [1:0] modeReg, modeNext;
    source_type selPrimaryReg, selPrimaryNext;
    source_type selBackup1Reg, selBackup1Next;
    source_type selBackup2Reg, selBackup2Next;
    logic startReg, startNext;

    // Routing state
    source_type routePrimary, routeBackup1, routeBackup2;
    source_type primarySlotReg, firstBackupSlotReg, secondBackupSlotReg;

    // Callout state
    state_type stateReg, stateNext;
    logic reqSentReg, reqSentNext;
    logic callReqNext;
    source_type callSourceNext;
    source_type activeNext;
    logic timeValidReg, timeValidNext;
    logic freeRunReg, freeRunNext;
    callstat_type statReg [4];
    callstat_type statNext [4];

    logic busWrite;
    logic callResolved;
    logic [DATA_WIDTH-1:0] statusWord;

    assign busWrite = wb_cyc_i && wb_stb_i && wb_we_i && ackReg;
    assign callResolved = reqSentReg && callDone;

    always_comb begin
        statusWord = '0;
        statusWord[STAT_STATE_LSB +: 3] = stateReg;
        statusWord[STAT_ACTIVE_LSB +: 2] = activeSource;
        statusWord[STAT_VALID_BIT] = timeValidReg;
        statusWord[STAT_FREE_BIT] = freeRunReg;
        for (int i = 0; i < 4; i++) begin
            statusWord[STAT_CALL_LSB + 2*i +: 2] = statReg[i]; // [RULE9]
        end
    end

    // Classic Wishbone slave: ack one cycle after the strobe, writes land on the acked edge
    always_comb begin
        ackNext = wb_cyc_i && wb_stb_i && !ackReg;
        rdataNext = rdataReg;
        modeNext = modeReg;
        selPrimaryNext = selPrimaryReg;
        selBackup1Next = selBackup1Reg;
        selBackup2Next = selBackup2Reg;
        startNext = 1'b0;
        if (ackNext && !wb_we_i) begin
            case (wb_adr_i)
                MODE_OFFSET: rdataNext = {30'h0, modeReg};
                SELECT_OFFSET: rdataNext = {26'h0, selBackup2Reg, selBackup1Reg, selPrimaryReg};
                STATUS_OFFSET: rdataNext = statusWord;
                default: rdataNext = '0;
            endcase
        end
        if (busWrite && wb_sel_i[0]) begin
            case (wb_adr_i)
                MODE_OFFSET: begin
                    modeNext = wb_dat_i[MODE_LSB +: 2]; // [RULE10]
                end
                SELECT_OFFSET: begin
                    selPrimaryNext = source_type'(wb_dat_i[SEL_PRIMARY_LSB +: 2]);
                    selBackup1Next = source_type'(wb_dat_i[SEL_BACKUP1_LSB +: 2]);
                    selBackup2Next = source_type'(wb_dat_i[SEL_BACKUP2_LSB +: 2]);
                end
                COMMAND_OFFSET: begin
                    startNext = wb_dat_i[CMD_START_BIT];
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ackReg <= 1'b0;
            rdataReg <= '0;
            modeReg <= MODE_RESET;
            selPrimaryReg <= source_type'(SELECT_RESET[SEL_PRIMARY_LSB +: 2]);
            selBackup1Reg <= source_type'(SELECT_RESET[SEL_BACKUP1_LSB +: 2]);
            selBackup2Reg <= source_type'(SELECT_RESET[SEL_BACKUP2_LSB +: 2]);
            startReg <= 1'b0;
        end else begin
            ackReg <= ackNext;
            rdataReg <= rdataNext;
            modeReg <= modeNext;
            selPrimaryReg <= selPrimaryNext;
            selBackup1Reg <= selBackup1Next;
            selBackup2Reg <= selBackup2Next;
            startReg <= startNext;
        end
    end

    assign wb_ack_o = ackReg;
    assign wb_dat_o = rdataReg;

    source_port_router router (
        .mode(modeReg),
        .selPrimary(selPrimaryReg),
        .selBackup1(selBackup1Reg),
        .selBackup2(selBackup2Reg),
        .primarySlot(routePrimary),
        .firstBackupSlot(routeBackup1),
        .secondBackupSlot(routeBackup2)
    );

    // Routing follows the mode on every cycle, even in the middle of a callout
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            primarySlotReg <= SRC_NONE;
            firstBackupSlotReg <= SRC_NONE;
            secondBackupSlotReg <= SRC_NONE;
        end else begin
            primarySlotReg <= routePrimary; // [RULE10]
            firstBackupSlotReg <= routeBackup1;
            secondBackupSlotReg <= (isDual(modeReg) || routeBackup2 == SRC_PHONE_MODEM) &&
                isDual(modeReg) ? SRC_NONE : routeBackup2; // [RULE8]
        end
    end

    function automatic source_type slotTarget(input state_type st, input source_type p,
            input source_type b1, input source_type b2);
        case (st)
            ST_CALL_PRIMARY: slotTarget = p;
            ST_CALL_BACKUP1: slotTarget = b1;
            ST_CALL_BACKUP2: slotTarget = b2;
            default: slotTarget = SRC_NONE;
        endcase
    endfunction : slotTarget

    // Failover sequence; an empty slot counts as a failed callout
    always_comb begin
        source_type target;
        logic failed;
        target = slotTarget(stateReg, primarySlotReg, firstBackupSlotReg, secondBackupSlotReg);
        failed = 1'b0;
        stateNext = stateReg;
        reqSentNext = reqSentReg;
        callReqNext = 1'b0;
        callSourceNext = callSource;
        activeNext = activeSource;
        timeValidNext = timeValidReg;
        freeRunNext = freeRunReg;
        for (int i = 0; i < 4; i++) begin
            statNext[i] = statReg[i];
        end
        case (stateReg)
            ST_IDLE, ST_LOCKED, ST_FREE_RUN: begin
                if (startReg) begin
                    stateNext = ST_CALL_PRIMARY;
                    reqSentNext = 1'b0;
                end
            end
            ST_CALL_PRIMARY, ST_CALL_BACKUP1, ST_CALL_BACKUP2: begin
                if (!reqSentReg) begin
                    if (target == SRC_NONE || (isDual(modeReg) && target == SRC_PHONE_MODEM)) begin
                        failed = 1'b1; // [RULE7]
                    end else begin
                        callReqNext = 1'b1;
                        callSourceNext = target;
                        reqSentNext = 1'b1;
                    end
                end else if (callResolved) begin
                    statNext[callSource] = callOk ? CALL_NORMAL : CALL_FAILED; // [RULE9]
                    if (callOk) begin
                        stateNext = ST_LOCKED;
                        activeNext = callSource;
                        timeValidNext = 1'b1; // [RULE9]
                        freeRunNext = 1'b0;
                    end else begin
                        failed = 1'b1; // [RULE4]
                    end
                end
                if (failed) begin
                    reqSentNext = 1'b0;
                    if (stateReg == ST_CALL_PRIMARY) begin
                        stateNext = ST_CALL_BACKUP1; // [RULE3]
                    end else if (stateReg == ST_CALL_BACKUP1 && secondBackupSlotReg != SRC_NONE) begin
                        stateNext = ST_CALL_BACKUP2; // [RULE5]
                    end else begin
                        stateNext = ST_FREE_RUN; // [RULE6]
                        activeNext = SRC_NONE;
                        timeValidNext = 1'b0;
                        freeRunNext = 1'b1;
                    end
                end
            end
            default: begin
                stateNext = ST_IDLE;
                reqSentNext = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            stateReg <= ST_IDLE;
            reqSentReg <= 1'b0;
            callReq <= 1'b0;
            callSource <= SRC_NONE;
            activeSource <= SRC_NONE;
            timeValidReg <= 1'b0;
            freeRunReg <= 1'b0;
            for (int i = 0; i < 4; i++) begin
                statReg[i] <= CALL_NEVER;
            end
        end else begin
            stateReg <= stateNext;
            reqSentReg <= reqSentNext;
            callReq <= callReqNext;
            callSource <= callSourceNext;
            activeSource <= activeNext;
            timeValidReg <= timeValidNext;
            freeRunReg <= freeRunNext;
            for (int i = 0; i < 4; i++) begin
                statReg[i] <= statNext[i];
            end
        end
    end

    assign timeValid = timeValidReg;
    assign freeRun = freeRunReg;

    logic inCall;
    assign inCall = stateReg == ST_CALL_PRIMARY || stateReg == ST_CALL_BACKUP1 ||
        stateReg == ST_CALL_BACKUP2;

    AST_MAP_SECONDARY_PRIMARY: assert property (@(posedge clk) disable iff (!nrst) // [RULE1]
        modeReg == MODE_SECONDARY_PORT_AS_PRIMARY |=>
            primarySlotReg == SRC_SECONDARY_PORT && firstBackupSlotReg == SRC_PRIMARY_PORT)
        else $error("secondary-as-primary mapping wrong");

    AST_MAP_PRIMARY_PRIMARY: assert property (@(posedge clk) disable iff (!nrst) // [RULE2]
        modeReg == MODE_SECONDARY_PORT_AS_BACKUP |=>
            primarySlotReg == SRC_PRIMARY_PORT && firstBackupSlotReg == SRC_SECONDARY_PORT)
        else $error("primary-as-primary mapping wrong");

    AST_NO_PRIMARY_RETRY: assert property (@(posedge clk) disable iff (!nrst) // [RULE3]
        stateReg == ST_CALL_PRIMARY && callResolved && !callOk |=>
            stateReg == ST_CALL_BACKUP1 && !callReq)
        else $error("primary failure did not move to first backup");

    AST_BACKUP_BY_CALL_ONLY: assert property (@(posedge clk) disable iff (!nrst) // [RULE4]
        stateReg == ST_CALL_BACKUP1 && !callResolved && firstBackupSlotReg != SRC_NONE &&
            !(isDual(modeReg) && firstBackupSlotReg == SRC_PHONE_MODEM) |=>
            stateReg == ST_CALL_BACKUP1)
        else $error("first backup left without its own callout result");

    AST_SECOND_BACKUP_USED: assert property (@(posedge clk) disable iff (!nrst) // [RULE5]
        stateReg == ST_CALL_BACKUP1 && callResolved && !callOk &&
            secondBackupSlotReg != SRC_NONE |=> stateReg == ST_CALL_BACKUP2 ##1 callReq)
        else $error("second backup not called");

    AST_FREE_RUN_LAST: assert property (@(posedge clk) disable iff (!nrst) // [RULE6]
        stateReg == ST_CALL_BACKUP2 && callResolved && !callOk |=>
            freeRun && !timeValid && stateReg == ST_FREE_RUN)
        else $error("free run not entered");

    AST_NO_PHONE_IN_DUAL: assert property (@(posedge clk) disable iff (!nrst) // [RULE7]
        isDual(modeReg) |=> primarySlotReg != SRC_PHONE_MODEM &&
            firstBackupSlotReg != SRC_PHONE_MODEM && secondBackupSlotReg != SRC_PHONE_MODEM)
        else $error("phone modem selectable in dual mode");

    AST_NO_BACKUP2_IN_DUAL: assert property (@(posedge clk) disable iff (!nrst) // [RULE8]
        isDual(modeReg) ##1 isDual(modeReg) |-> secondBackupSlotReg == SRC_NONE &&
            !(callReq && stateReg == ST_CALL_BACKUP2))
        else $error("second backup used in dual mode");

    AST_CALL_STATUS_KEPT: assert property (@(posedge clk) disable iff (!nrst) // [RULE9]
        inCall && callResolved |=>
            statReg[$past(callSource)] == ($past(callOk) ? CALL_NORMAL : CALL_FAILED) &&
            timeValid == ($past(callOk) || ($past(timeValidReg) && !freeRun)))
        else $error("callout status not recorded");

    AST_MODE_APPLIED: assert property (@(posedge clk) disable iff (!nrst) // [RULE10]
        busWrite && wb_sel_i[0] && wb_adr_i == MODE_OFFSET &&
            wb_dat_i[1:0] == MODE_SECONDARY_PORT_AS_PRIMARY |=>
            ##1 primarySlotReg == SRC_SECONDARY_PORT)
        else $error("mode change not routed");
endmodule : dual_serial_source_failover

`default_nettype wire

// file: source_port_router.sv
`default_nettype none

package failover_pkg;
    localparam int unsigned DATA_WIDTH = 32;
    localparam int unsigned ADDR_WIDTH = 8;
    localparam int unsigned SEL_WIDTH = 4;

    // Register byte offsets
    localparam logic [7:0] MODE_OFFSET = 8'h00;
    localparam logic [7:0] SELECT_OFFSET = 8'h04;
    localparam logic [7:0] COMMAND_OFFSET = 8'h08;
    localparam logic [7:0] STATUS_OFFSET = 8'h0C;

    // Field positions
    localparam int unsigned MODE_LSB = 0;
    localparam int unsigned SEL_PRIMARY_LSB = 0;
    localparam int unsigned SEL_BACKUP1_LSB = 2;
    localparam int unsigned SEL_BACKUP2_LSB = 4;
    localparam int unsigned CMD_START_BIT = 0;
    localparam int unsigned STAT_STATE_LSB = 0;
    localparam int unsigned STAT_ACTIVE_LSB = 4;
    localparam int unsigned STAT_VALID_BIT = 6;
    localparam int unsigned STAT_FREE_BIT = 7;
    localparam int unsigned STAT_CALL_LSB = 8;

    // Reset values
    localparam logic [1:0] MODE_RESET = 2'h0;
    localparam logic [5:0] SELECT_RESET = 6'h00;

    // Dual-port mode values; 2'h3 behaves as off
    localparam logic [1:0] MODE_OFF = 2'h0;
    localparam logic [1:0] MODE_SECONDARY_PORT_AS_BACKUP = 2'h1;
    localparam logic [1:0] MODE_SECONDARY_PORT_AS_PRIMARY = 2'h2;

    typedef enum logic [1:0] {
        SRC_NONE = 2'h0,
        SRC_PRIMARY_PORT = 2'h1,
        SRC_SECONDARY_PORT = 2'h2,
        SRC_PHONE_MODEM = 2'h3
    } source_type;

    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_CALL_PRIMARY = 3'h1,
        ST_CALL_BACKUP1 = 3'h3,
        ST_CALL_BACKUP2 = 3'h2,
        ST_LOCKED = 3'h6,
        ST_FREE_RUN = 3'h7
    } state_type;

    typedef enum logic [1:0] {
        CALL_NEVER = 2'h0,
        CALL_NORMAL = 2'h1,
        CALL_FAILED = 2'h2
    } callstat_type;

    function automatic logic isDual(input logic [1:0] mode);
        isDual = (mode == MODE_SECONDARY_PORT_AS_BACKUP) ||
                 (mode == MODE_SECONDARY_PORT_AS_PRIMARY);
    endfunction : isDual
endpackage : failover_pkg

module source_port_router (
    input wire logic [1:0] mode,
    input wire failover_pkg::source_type selPrimary,
    input wire failover_pkg::source_type selBackup1,
    input wire failover_pkg::source_type selBackup2,
    output failover_pkg::source_type primarySlot,
    output failover_pkg::source_type firstBackupSlot,
    output failover_pkg::source_type secondBackupSlot
);
    import failover_pkg::*;

    // Single-port operation: the secondary port is not wired out of the connector
    function automatic source_type singlePortSource(input source_type sel);
        singlePortSource = (sel == SRC_SECONDARY_PORT) ? SRC_NONE : sel;
    endfunction : singlePortSource

    always_comb begin
        if (mode == MODE_SECONDARY_PORT_AS_PRIMARY) begin
            primarySlot = SRC_SECONDARY_PORT; // [RULE1]
            firstBackupSlot = SRC_PRIMARY_PORT; // [RULE1]
            secondBackupSlot = SRC_NONE; // [RULE8]
        end else if (mode == MODE_SECONDARY_PORT_AS_BACKUP) begin
            primarySlot = SRC_PRIMARY_PORT; // [RULE2]
            firstBackupSlot = SRC_SECONDARY_PORT; // [RULE2]
            secondBackupSlot = SRC_NONE; // [RULE8]
        end else begin
            primarySlot = singlePortSource(selPrimary);
            firstBackupSlot = singlePortSource(selBackup1);
            secondBackupSlot = singlePortSource(selBackup2);
        end
    end
endmodule : source_port_router

`default_nettype wire

// file: time_source_model.sv
`default_nettype none

// Far-side time source: answers each callout once, after a set latency,
// with the verdict taken from a per-call pattern
module time_source_model (
    input wire logic clk,
    input wire logic nrst,
    input wire logic callReq,
    input wire failover_pkg::source_type callSource,
    input wire logic [15:0] okPattern,
    input wire logic [7:0] latency,
    output logic callDone,
    output logic callOk
);
    timeunit 1ns;
    timeprecision 1ps;
    import failover_pkg::*;

    logic pending;
    logic [7:0] waitCnt;
    logic [3:0] callIdx;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            pending <= 1'b0;
            waitCnt <= 8'h00;
            callIdx <= 4'h0;
            callDone <= 1'b0;
            callOk <= 1'b0;
        end else begin
            callDone <= 1'b0;
            // Outside an answer the verdict line keeps flipping, so it is never trusted
            callOk <= ~callOk;
            if (callReq && !pending) begin
                pending <= 1'b1;
                waitCnt <= 8'h00;
            end else if (pending && waitCnt == latency) begin
                // One answer for each request
                pending <= 1'b0;
                callDone <= 1'b1;
                callOk <= okPattern[callIdx];
                callIdx <= callIdx + 4'h1;
            end else if (pending) begin
                waitCnt <= waitCnt + 8'h01;
            end
        end
    end
endmodule : time_source_model

`default_nettype wire

// file: testbench.sv
`default_nettype none

`define CHECK(a, b) begin cmp_count++; if ((a) !== (b)) begin error_cnt++; \
    $display("[ERR] %0t got %0h expected %0h", $time, (a), (b)); end end

module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import failover_pkg::*;

    logic clk, nrst, wb_cyc_i, wb_stb_i, wb_we_i, callReq, callDone, callOk;
    logic timeValid, freeRun, wb_ack_o;
    logic [7:0] wb_adr_i, latency;
    logic [3:0] wb_sel_i;
    logic [31:0] wb_dat_i, wb_dat_o, rd;
    logic [15:0] okPattern;
    source_type callSource, activeSource;
    source_type srcLog [0:15];
    int error_cnt = 0;
    int cmp_count = 0;
    int callCnt = 0;
    int cycles = 0;

    dual_serial_source_failover DUT (.clk(clk), .nrst(nrst), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
        .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .callReq(callReq),
        .callSource(callSource), .callDone(callDone), .callOk(callOk),
        .activeSource(activeSource), .timeValid(timeValid), .freeRun(freeRun));

    time_source_model partner (.clk(clk), .nrst(nrst), .callReq(callReq),
        .callSource(callSource), .okPattern(okPattern), .latency(latency),
        .callDone(callDone), .callOk(callOk));

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    always @(posedge clk) begin
        if (callReq === 1'b1) begin
            srcLog[callCnt] = callSource;
            callCnt++;
        end
        cycles++;
        // Whole run needs a few hundred cycles; far beyond that means a hang
        if (cycles == 20000) begin
            error_cnt++;
            stop_test();
        end
    end

    task automatic stop_test();
        $display("Comparisons %0d, mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : stop_test

    task automatic wb_cycle(input logic we, input logic [7:0] adr, input logic [31:0] wdat);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_sel_i <= 4'hF;
        wb_dat_i <= wdat;
        // No local limit: a missing ack is caught by the run-wide timeout
        do begin
            @(posedge clk);
        end while (wb_ack_o !== 1'b1);
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
        @(posedge clk);
    endtask : wb_cycle

    task automatic wb_check(input logic [7:0] adr, input logic [31:0] exp);
        wb_cycle(1'b0, adr, 32'h0000_0000);
        `CHECK(rd, exp)
    endtask : wb_check

    // One failover sequence: configure, start, wait, then compare the call order and outcome
    task automatic run_seq(input logic [1:0] m, input logic [5:0] sel, input logic [7:0] lat,
                           input int ncalls, input logic [7:0] srcs, input logic [31:0] expStat);
        int base;
        int n;
        base = callCnt;
        latency <= lat;
        wb_cycle(1'b1, MODE_OFFSET, {30'h0, m});
        wb_cycle(1'b1, SELECT_OFFSET, {26'h0, sel});
        wb_check(SELECT_OFFSET, {26'h0, sel});
        wb_cycle(1'b1, COMMAND_OFFSET, 32'h0000_0001);
        // A second start while the first is still calling must not restart anything
        if (lat > 8'h08) wb_cycle(1'b1, COMMAND_OFFSET, 32'h0000_0001);
        n = 0;
        do begin
            wb_cycle(1'b0, STATUS_OFFSET, 32'h0000_0000);
            n++;
        end while (rd[2:0] !== 3'h6 && rd[2:0] !== 3'h7 && n < 200);
        `CHECK(rd, expStat)
        `CHECK(callCnt - base, ncalls)
        for (int k = 0; k < ncalls; k++) begin
            `CHECK(srcLog[base + k], source_type'(srcs[2 * k +: 2]))
        end
        `CHECK(activeSource, source_type'(expStat[5:4]))
        `CHECK(timeValid, expStat[6])
        `CHECK(freeRun, expStat[7])
    endtask : run_seq

    initial begin
        nrst = 1'b0;
        wb_cyc_i = 1'b0;
        wb_stb_i = 1'b0;
        wb_we_i = 1'b0;
        wb_adr_i = 8'h00;
        wb_sel_i = 4'h0;
        wb_dat_i = 32'h0000_0000;
        // Calls 0..6 answer fail, ok, fail, fail, fail, fail, ok; every later call fails
        okPattern = 16'h0042;
        latency = 8'h00;
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        `CHECK(freeRun, 1'b0)
        wb_check(MODE_OFFSET, 32'h0000_0000);
        wb_check(SELECT_OFFSET, 32'h0000_0000);
        wb_check(STATUS_OFFSET, 32'h0000_0000);
        wb_check(COMMAND_OFFSET, 32'h0000_0000);
        wb_cycle(1'b1, 8'h10, 32'h0000_0002);
        wb_check(8'h10, 32'h0000_0000);
        wb_check(MODE_OFFSET, 32'h0000_0000);
        wb_cycle(1'b1, STATUS_OFFSET, 32'h0000_00FF);
        wb_check(STATUS_OFFSET, 32'h0000_0000);
        // Secondary port first, fails, then primary port once, locks; modem never used
        run_seq(2'h2, 6'h3F, 8'h1E, 2, 8'h06, 32'h0000_2456);
        // Primary port then secondary fail; configured second backup is not used
        run_seq(2'h1, 6'h30, 8'h00, 2, 8'h09, 32'h0000_2887);
        // Off mode: modem, primary port, then second backup modem succeeds
        run_seq(2'h0, 6'h37, 8'h02, 3, 8'h37, 32'h0000_6876);
        // Off mode with no usable slot: straight to free run without any callout
        run_seq(2'h0, 6'h02, 8'h00, 0, 8'h00, 32'h0000_6887);
        // Mode 3 behaves as off: all three slots called and failed, then free run
        run_seq(2'h3, 6'h1D, 8'h00, 3, 8'h1D, 32'h0000_A887);
        stop_test();
    end
endmodule : testbench

`undef CHECK

`default_nettype wire
